// >>> sgd_dma.sv
// Scatter/gather descriptor mover with AXI4-Lite registers.
// Assumes a same-clock memory port that acks each request with a pulse.
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps

module sgd_buf #(
  parameter int W = 34
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  // Main plus skid entry; all outputs are flops
  logic main_v_q, main_v_d, skid_v_q, skid_v_d;
  logic [W-1:0] main_q, main_d, skid_q, skid_d;
  wire push = in_valid_i & in_ready_o;
  always_comb
  begin
    main_v_d = main_v_q;
    main_d = main_q;
    skid_v_d = skid_v_q;
    skid_d = skid_q;
    if (out_ready_i | ~main_v_q)
    begin
      if (skid_v_q)
      begin
        main_d = skid_q;
        main_v_d = 1'b1;
        skid_v_d = 1'b0;
      end
      else
      begin
        main_v_d = push;
        main_d = in_data_i;
      end
    end
    else if (push)
    begin
      skid_v_d = 1'b1;
      skid_d = in_data_i;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      main_v_q <= 1'b0;
      skid_v_q <= 1'b0;
      main_q <= '0;
      skid_q <= '0;
      in_ready_o <= 1'b1;
    end
    else
    begin
      main_v_q <= main_v_d;
      skid_v_q <= skid_v_d;
      main_q <= main_d;
      skid_q <= skid_d;
      in_ready_o <= ~skid_v_d;
    end
  end
  assign out_valid_o = main_v_q;
  assign out_data_o = main_q;
endmodule // sgd_buf

module sgd_dma
  import sgd_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // AXI4-Lite slave
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // System memory port
  output logic MEM_REQ_O,
  output logic MEM_WE_O,
  output logic [31:0] MEM_ADDR_O,
  output logic [7:0] MEM_AM_O,
  output logic [1:0] MEM_SIZE_O,
  output logic [31:0] MEM_WDATA_O,
  input wire logic [31:0] MEM_RDATA_I,
  input wire logic MEM_ACK_I,
  // Data from memory toward the device
  output logic DOUT_VALID_O,
  input wire logic DOUT_READY_I,
  output logic [31:0] DOUT_DATA_O,
  output logic [1:0] DOUT_SIZE_O,
  // Data from the device toward memory
  input wire logic DIN_VALID_I,
  output logic DIN_READY_O,
  input wire logic [31:0] DIN_DATA_I
);
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] wd, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (st[i]) r[8*i +: 8] = wd[8*i +: 8];
    return r;
  endfunction
  function automatic logic [31:0] nbytes(input logic [1:0] sz);
    return (sz == SGD_SZ32) ? 32'h0000_0004 :
      (sz == SGD_SZ16) ? 32'h0000_0002 : 32'h0000_0001;
  endfunction
  // One width for the whole segment
  function automatic logic [1:0] std_size(input logic [31:0] a,
    input logic [31:0] n, input logic wide);
    if (wide && a[1:0] == 2'h0 && n[1:0] == 2'h0) return SGD_SZ32;
    if (a[0] == 1'b0 && n[0] == 1'b0) return SGD_SZ16;
    return SGD_SZ8;
  endfunction
  // Per-beat width gives lead, aligned body and tail pieces
  function automatic logic [1:0] odd_size(input logic [31:0] a,
    input logic [31:0] n, input logic wide);
    if (wide && a[1:0] == 2'h0 && n >= 32'h0000_0004) return SGD_SZ32;
    if (a[0] == 1'b0 && n >= 32'h0000_0002) return SGD_SZ16;
    return SGD_SZ8;
  endfunction

  sgd_state_type state_q;
  logic [31:0] ctrl_q, addr_q, count_q, moved_q;
  logic done_q, aw_v_q, w_v_q;
  logic [7:0] aw_a_q;
  logic [31:0] w_d_q;
  logic [3:0] w_s_q;
  logic [31:0] base_q, next_q, cur_addr_q, cur_len_q;
  logic [7:0] cur_am_q;
  logic [1:0] size_q;
  logic [4:0] fidx_q;
  logic [3:0] seg_q;
  logic single_q, end_q, rx_push_q;
  logic [33:0] rx_data_q;
  logic [7:0] seg_am [SGD_SEG_NUM];
  logic [23:0] seg_len [SGD_SEG_NUM];
  logic [31:0] seg_addr [SGD_SEG_NUM];

  // Register decode
  wire wr_go = aw_v_q & w_v_q & ~S_AXI_BVALID_O;
  wire wr_ctrl = wr_go & (aw_a_q == SGD_CTRL_OFS);
  wire wr_addr = wr_go & (aw_a_q == SGD_ADDR_OFS);
  wire wr_count = wr_go & (aw_a_q == SGD_COUNT_OFS);
  wire wr_stat = wr_go & (aw_a_q == SGD_STAT_OFS);
  wire wr_hit = wr_ctrl | wr_addr | wr_count | wr_stat;
  wire busy = (state_q != SGD_IDLE);
  wire start = wr_ctrl & w_s_q[0] & w_d_q[SGD_START_BIT] & ~busy;
  wire done_clr = wr_stat & w_s_q[0] & w_d_q[SGD_DONE_BIT];
  // Start must see the mode bits of the word that starts it
  wire [31:0] ctrl_nx = merge(ctrl_q, w_d_q, w_s_q);
  wire rd_take = S_AXI_ARVALID_I & S_AXI_ARREADY_O;
  wire [31:0] status = {26'h0, end_q, seg_q[2:0], done_q, busy};
  wire rd_hit = (S_AXI_ARADDR_I == SGD_CTRL_OFS) |
    (S_AXI_ARADDR_I == SGD_ADDR_OFS) | (S_AXI_ARADDR_I == SGD_COUNT_OFS) |
    (S_AXI_ARADDR_I == SGD_STAT_OFS) | (S_AXI_ARADDR_I == SGD_MOVED_OFS);
  wire [31:0] rd_mux =
    (S_AXI_ARADDR_I == SGD_CTRL_OFS) ? {ctrl_q[31:1], 1'b0} :
    (S_AXI_ARADDR_I == SGD_ADDR_OFS) ? addr_q :
    (S_AXI_ARADDR_I == SGD_COUNT_OFS) ? count_q :
    (S_AXI_ARADDR_I == SGD_STAT_OFS) ? status :
    (S_AXI_ARADDR_I == SGD_MOVED_OFS) ? moved_q : SGD_WORD_RST;

  // Engine decode
  wire to_mem = ctrl_q[SGD_TOMEM_BIT];
  wire wide = ctrl_q[SGD_WIDE_BIT];
  wire [4:0] fidx_m1 = fidx_q - 5'h01;
  wire [2:0] fseg = fidx_m1[3:1];
  wire [2:0] pseg = seg_q[2:0];
  wire seg_empty = seg_q[3] | (seg_len[pseg] == 24'h00_0000);
  wire [1:0] beat_size = ctrl_q[SGD_ODD_BIT] ?
    odd_size(cur_addr_q, cur_len_q, wide) : size_q;
  wire [31:0] beat_n = nbytes(MEM_SIZE_O);
  wire tx_valid, rx_ready;
  wire [33:0] tx_data;
  wire tx_pop = (state_q == SGD_REQ) & to_mem & tx_valid &
    (cur_len_q != SGD_WORD_RST);
  // Ready lags a push by one cycle; wait for it so no word is lost
  wire rx_ok = to_mem | (rx_ready & ~rx_push_q);

  sgd_buf #(.W(34)) u_rx (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .in_valid_i(rx_push_q),
    .in_ready_o(rx_ready),
    .in_data_i(rx_data_q),
    .out_valid_o(DOUT_VALID_O),
    .out_ready_i(DOUT_READY_I),
    .out_data_o({DOUT_SIZE_O, DOUT_DATA_O})
  );
  sgd_buf #(.W(34)) u_tx (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .in_valid_i(DIN_VALID_I),
    .in_ready_o(DIN_READY_O),
    .in_data_i({2'h0, DIN_DATA_I}),
    .out_valid_o(tx_valid),
    .out_ready_i(tx_pop),
    .out_data_o(tx_data)
  );

  // AXI4-Lite slave
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      S_AXI_AWREADY_O <= 1'b1;
      S_AXI_WREADY_O <= 1'b1;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= SGD_OKAY;
      S_AXI_ARREADY_O <= 1'b1;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RRESP_O <= SGD_OKAY;
      S_AXI_RDATA_O <= SGD_WORD_RST;
      aw_v_q <= 1'b0;
      w_v_q <= 1'b0;
      aw_a_q <= 8'h00;
      w_d_q <= SGD_WORD_RST;
      w_s_q <= 4'h0;
      ctrl_q <= SGD_CTRL_RST;
      addr_q <= SGD_WORD_RST;
      count_q <= SGD_WORD_RST;
      done_q <= 1'b0;
    end
    else
    begin
      if (S_AXI_AWVALID_I & S_AXI_AWREADY_O)
      begin
        aw_v_q <= 1'b1;
        aw_a_q <= S_AXI_AWADDR_I;
        S_AXI_AWREADY_O <= 1'b0;
      end
      if (S_AXI_WVALID_I & S_AXI_WREADY_O)
      begin
        w_v_q <= 1'b1;
        w_d_q <= S_AXI_WDATA_I;
        w_s_q <= S_AXI_WSTRB_I;
        S_AXI_WREADY_O <= 1'b0;
      end
      if (wr_go)
      begin
        aw_v_q <= 1'b0;
        w_v_q <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O <= wr_hit ? SGD_OKAY : SGD_SLVERR;
      end
      if (S_AXI_BVALID_O & S_AXI_BREADY_I)
      begin
        S_AXI_BVALID_O <= 1'b0;
        S_AXI_AWREADY_O <= 1'b1;
        S_AXI_WREADY_O <= 1'b1;
      end
      // Mode bits are frozen while a transfer runs
      if (wr_ctrl & ~busy)
        ctrl_q <= merge(ctrl_q, w_d_q, w_s_q) & ~32'h0000_0001;
      if (wr_addr & ~busy)
        addr_q <= merge(addr_q, w_d_q, w_s_q);
      if (wr_count & ~busy)
        count_q <= merge(count_q, w_d_q, w_s_q);
      // Completion beats a clear in the same cycle
      if (state_q == SGD_REQ && cur_len_q == SGD_WORD_RST && single_q)
        done_q <= 1'b1;
      else if (state_q == SGD_PICK && seg_empty && next_q == SGD_END_MARK)
        done_q <= 1'b1;
      else if (done_clr)
        done_q <= 1'b0;
      if (rd_take)
      begin
        S_AXI_ARREADY_O <= 1'b0;
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RDATA_O <= rd_mux;
        S_AXI_RRESP_O <= rd_hit ? SGD_OKAY : SGD_SLVERR;
      end
      else if (S_AXI_RVALID_O & S_AXI_RREADY_I)
      begin
        S_AXI_RVALID_O <= 1'b0;
        S_AXI_ARREADY_O <= 1'b1;
      end
    end
  end

  // Descriptor storage doubles as the next-segment preload
  always_ff @(posedge CLK_I)
  begin
    if (state_q == SGD_FETCH && MEM_ACK_I && fidx_q != 5'h00)
    begin
      if (fidx_q[0])
      begin
        seg_am[fseg] <= MEM_RDATA_I[31:SGD_AM_LSB_D];
        seg_len[fseg] <= MEM_RDATA_I[23:0];
      end
      else
        seg_addr[fseg] <= MEM_RDATA_I;
    end
  end

  // Transfer engine
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      state_q <= SGD_IDLE;
      MEM_REQ_O <= 1'b0;
      MEM_WE_O <= 1'b0;
      MEM_ADDR_O <= SGD_WORD_RST;
      MEM_AM_O <= 8'h00;
      MEM_SIZE_O <= SGD_SZ8;
      MEM_WDATA_O <= SGD_WORD_RST;
      base_q <= SGD_WORD_RST;
      next_q <= SGD_END_MARK;
      cur_addr_q <= SGD_WORD_RST;
      cur_len_q <= SGD_WORD_RST;
      cur_am_q <= 8'h00;
      size_q <= SGD_SZ8;
      fidx_q <= 5'h00;
      seg_q <= 4'h0;
      single_q <= 1'b0;
      end_q <= 1'b0;
      moved_q <= SGD_WORD_RST;
      rx_push_q <= 1'b0;
      rx_data_q <= '0;
    end
    else
    begin
      rx_push_q <= 1'b0;
      unique case (state_q)
        SGD_IDLE:
        begin
          if (start)
          begin
            moved_q <= SGD_WORD_RST;
            end_q <= 1'b0;
            seg_q <= 4'h0;
            single_q <= ~ctrl_nx[SGD_SG_BIT];
            if (ctrl_nx[SGD_SG_BIT])
            begin
              base_q <= addr_q;
              fidx_q <= 5'h00;
              state_q <= SGD_FETCH;
            end
            else
            begin
              cur_addr_q <= addr_q;
              cur_len_q <= count_q;
              cur_am_q <= ctrl_nx[SGD_AM_LSB +: 8];
              size_q <= std_size(addr_q, count_q,
                ctrl_nx[SGD_WIDE_BIT]);
              state_q <= SGD_REQ;
            end
          end
        end
        SGD_FETCH:
        begin
          MEM_REQ_O <= ~MEM_ACK_I;
          MEM_WE_O <= 1'b0;
          MEM_ADDR_O <= base_q + {25'h0, fidx_q, 2'b00};
          MEM_AM_O <= ctrl_q[SGD_AM_LSB +: 8];
          MEM_SIZE_O <= SGD_SZ32;
          if (MEM_ACK_I)
          begin
            if (fidx_q == 5'h00)
              next_q <= MEM_RDATA_I;
            fidx_q <= fidx_q + 5'h01;
            if (fidx_q == SGD_DESC_LAST)
            begin
              seg_q <= 4'h0;
              state_q <= SGD_PICK;
            end
          end
        end
        SGD_PICK:
        begin
          if (seg_empty)
          begin
            if (next_q == SGD_END_MARK)
            begin
              end_q <= 1'b1;
              state_q <= SGD_IDLE;
            end
            else
            begin
              base_q <= next_q;
              fidx_q <= 5'h00;
              state_q <= SGD_FETCH;
            end
          end
          else
          begin
            cur_addr_q <= seg_addr[pseg];
            cur_len_q <= {8'h00, seg_len[pseg]};
            cur_am_q <= seg_am[pseg];
            size_q <= std_size(seg_addr[pseg], {8'h00, seg_len[pseg]},
              wide);
            seg_q <= seg_q + 4'h1;
            state_q <= SGD_REQ;
          end
        end
        SGD_REQ:
        begin
          if (cur_len_q == SGD_WORD_RST)
            state_q <= single_q ? SGD_IDLE : SGD_PICK;
          else if ((to_mem & tx_valid) | (~to_mem & rx_ok))
          begin
            MEM_REQ_O <= 1'b1;
            MEM_WE_O <= to_mem;
            MEM_ADDR_O <= cur_addr_q;
            MEM_AM_O <= cur_am_q;
            MEM_SIZE_O <= beat_size;
            MEM_WDATA_O <= tx_data[31:0];
            state_q <= SGD_WAIT;
          end
        end
        SGD_WAIT:
        begin
          if (MEM_ACK_I)
          begin
            MEM_REQ_O <= 1'b0;
            cur_addr_q <= cur_addr_q + beat_n;
            cur_len_q <= cur_len_q - beat_n;
            moved_q <= moved_q + beat_n;
            rx_push_q <= ~to_mem;
            rx_data_q <= {MEM_SIZE_O, MEM_RDATA_I};
            state_q <= SGD_REQ;
          end
        end
      endcase
    end
  end
endmodule // sgd_dma

// >>> sgd_dma_asserts.sv
// Port checker of the scatter/gather mover.
// Bound into sgd_dma; sees a subset of its ports.
`timescale 1ns/1ps
module sgd_dma_asserts
  import sgd_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // Register bus
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  // Memory port and stream
  input wire logic MEM_REQ_O,
  input wire logic [31:0] MEM_ADDR_O,
  input wire logic [7:0] MEM_AM_O,
  input wire logic [1:0] MEM_SIZE_O,
  input wire logic MEM_ACK_I,
  input wire logic DOUT_VALID_O,
  input wire logic DOUT_READY_I,
  input wire logic [31:0] DOUT_DATA_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);
  chk_wr_answer: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O &&
    S_AXI_WVALID_I && S_AXI_WREADY_O |=> !S_AXI_AWREADY_O ##1 S_AXI_BVALID_O)
    else $error("write not answered");
  chk_b_once: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I
    |=> !S_AXI_BVALID_O ##1 S_AXI_AWREADY_O)
    else $error("write response repeated");
  chk_rd_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O
    |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O)
    else $error("read not answered");
  chk_r_once: assert property (S_AXI_RVALID_O && S_AXI_RREADY_I
    |=> !S_AXI_RVALID_O)
    else $error("read response repeated");
  chk_req_hold: assert property (MEM_REQ_O && !MEM_ACK_I |=> MEM_REQ_O &&
    $stable(MEM_ADDR_O) && $stable(MEM_AM_O) && $stable(MEM_SIZE_O))
    else $error("memory request changed before ack");
  chk_ack_drop: assert property (MEM_REQ_O && MEM_ACK_I |=> !MEM_REQ_O)
    else $error("memory request held after ack");
  chk_size_align: assert property (MEM_REQ_O |-> MEM_SIZE_O == SGD_SZ8 ||
    (MEM_SIZE_O == SGD_SZ16 && !MEM_ADDR_O[0]) ||
    (MEM_SIZE_O == SGD_SZ32 && MEM_ADDR_O[1:0] == 2'h0))
    else $error("beat size does not fit address");
  chk_dout_hold: assert property (DOUT_VALID_O && !DOUT_READY_I
    |=> DOUT_VALID_O && $stable(DOUT_DATA_O))
    else $error("stream word lost in stall");
  cov_half: cover property (MEM_REQ_O && MEM_ACK_I && MEM_SIZE_O == SGD_SZ16);
  cov_stall: cover property (DOUT_VALID_O && !DOUT_READY_I);
  cov_slverr: cover property (S_AXI_BVALID_O && S_AXI_BRESP_O == SGD_SLVERR);
endmodule // sgd_dma_asserts
bind sgd_dma sgd_dma_asserts sgd_dma_asserts_i (.CLK_I, .RST_I,
  .S_AXI_AWVALID_I, .S_AXI_AWREADY_O, .S_AXI_WVALID_I, .S_AXI_WREADY_O,
  .S_AXI_BVALID_O, .S_AXI_BRESP_O, .S_AXI_BREADY_I, .S_AXI_ARVALID_I,
  .S_AXI_ARREADY_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I, .MEM_REQ_O,
  .MEM_ADDR_O, .MEM_AM_O, .MEM_SIZE_O, .MEM_ACK_I, .DOUT_VALID_O,
  .DOUT_READY_I, .DOUT_DATA_O);

// >>> sgd_mem_model.sv
// Partner memory on the mover's system memory port.
// Same clock; acks one cycle or four cycles after the request.
`timescale 1ns/1ps
module sgd_mem_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Request
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic slow_i,
  // Answer
  output logic ack_o,
  output logic [31:0] rdata_o
);
  logic [31:0] mem [0:255] = '{default: 32'h0000_0000};
  logic [1:0] wait_q;
  // Plain always: the bench also fills mem
  always @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      ack_o <= 1'b0;
      wait_q <= 2'h0;
      rdata_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= 1'b0;
      // Stale data must never look valid
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o && wait_q < (slow_i ? 2'h3 : 2'h0))
        wait_q <= wait_q + 2'h1;
      else if (req_i && !ack_o)
      begin
        ack_o <= 1'b1;
        wait_q <= 2'h0;
        rdata_o <= mem[addr_i[9:2]];
        if (we_i)
          mem[addr_i[9:2]] <= wdata_i;
      end
    end
endmodule // sgd_mem_model

// >>> sgd_pkg.sv
// Constants, register map and state codes of the scatter/gather mover.
// Assumes a 32-bit memory word and a 32-bit AXI4-Lite register bus.
package sgd_pkg;
  // Register byte offsets
  localparam logic [7:0] SGD_CTRL_OFS = 8'h00;
  localparam logic [7:0] SGD_ADDR_OFS = 8'h04;
  localparam logic [7:0] SGD_COUNT_OFS = 8'h08;
  localparam logic [7:0] SGD_STAT_OFS = 8'h0C;
  localparam logic [7:0] SGD_MOVED_OFS = 8'h10;
  // Control fields
  localparam int SGD_START_BIT = 0;
  localparam int SGD_SG_BIT = 1;
  localparam int SGD_TOMEM_BIT = 2;
  localparam int SGD_ODD_BIT = 3;
  localparam int SGD_WIDE_BIT = 4;
  localparam int SGD_AM_LSB = 8;
  localparam logic [31:0] SGD_CTRL_RST = 32'h0000_0010;
  localparam logic [31:0] SGD_WORD_RST = 32'h0000_0000;
  // Status fields
  localparam int SGD_BUSY_BIT = 0;
  localparam int SGD_DONE_BIT = 1;
  localparam int SGD_SEG_LSB = 2;
  // Descriptor layout
  localparam logic [31:0] SGD_END_MARK = 32'hFFFF_FFFF;
  localparam logic [4:0] SGD_DESC_LAST = 5'h10;
  localparam int SGD_SEG_NUM = 8;
  localparam int SGD_AM_LSB_D = 24;
  // Transfer sizes
  localparam logic [1:0] SGD_SZ8 = 2'h0;
  localparam logic [1:0] SGD_SZ16 = 2'h1;
  localparam logic [1:0] SGD_SZ32 = 2'h2;
  // Bus responses
  localparam logic [1:0] SGD_OKAY = 2'h0;
  localparam logic [1:0] SGD_SLVERR = 2'h2;
  typedef enum logic [4:0] {
    SGD_IDLE = 5'b00001,
    SGD_FETCH = 5'b00010,
    SGD_PICK = 5'b00100,
    SGD_REQ = 5'b01000,
    SGD_WAIT = 5'b10000
  } sgd_state_type;
endpackage

// >>> test_sgd_dma.sv
// Self-checking bench of the scatter/gather mover.
// AXI4-Lite master and streams here; memory is sgd_mem_model.
`timescale 1ns/1ps
module test_sgd_dma import sgd_pkg::*; ;
  logic CLK_I = 1'b0, RST_I = 1'b1, slow = 1'b0;
  logic [7:0] S_AXI_AWADDR_I = 8'h00, S_AXI_ARADDR_I = 8'h00, MEM_AM_O;
  logic [31:0] S_AXI_WDATA_I = 32'h0000_0000, DIN_DATA_I = 32'h0000_0000;
  logic S_AXI_AWVALID_I = 1'b0, S_AXI_WVALID_I = 1'b0, S_AXI_BREADY_I = 1'b0;
  logic S_AXI_ARVALID_I = 1'b0, S_AXI_RREADY_I = 1'b0, DIN_READY_O;
  logic DOUT_READY_I = 1'b1, DIN_VALID_I = 1'b0, S_AXI_AWREADY_O;
  logic S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
  logic MEM_REQ_O, MEM_WE_O, MEM_ACK_I, DOUT_VALID_O;
  logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O, MEM_SIZE_O, DOUT_SIZE_O;
  logic [31:0] S_AXI_RDATA_O, MEM_ADDR_O, MEM_WDATA_O, MEM_RDATA_I;
  logic [31:0] DOUT_DATA_O;
  logic [42:0] lq[$], eq[$];
  logic [33:0] dq[$];
  int error_cnt = 0, checks_done = 0;
  always #5 CLK_I = ~CLK_I;
  sgd_dma sgd_dma_i (.CLK_I, .RST_I, .S_AXI_AWADDR_I, .S_AXI_AWVALID_I,
    .S_AXI_AWREADY_O, .S_AXI_WDATA_I, .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I,
    .S_AXI_WREADY_O, .S_AXI_BRESP_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I,
    .S_AXI_ARADDR_I, .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RDATA_O,
    .S_AXI_RRESP_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I, .MEM_REQ_O, .MEM_WE_O,
    .MEM_ADDR_O, .MEM_AM_O, .MEM_SIZE_O, .MEM_WDATA_O, .MEM_RDATA_I,
    .MEM_ACK_I, .DOUT_VALID_O, .DOUT_READY_I, .DOUT_DATA_O, .DOUT_SIZE_O,
    .DIN_VALID_I, .DIN_READY_O, .DIN_DATA_I);
  sgd_mem_model sgd_mem_model_i (.clk_i(CLK_I), .rst_i(RST_I),
    .req_i(MEM_REQ_O), .we_i(MEM_WE_O), .addr_i(MEM_ADDR_O),
    .wdata_i(MEM_WDATA_O), .slow_i(slow), .ack_o(MEM_ACK_I),
    .rdata_o(MEM_RDATA_I));
  // Values read here are those before the edge
  always @(posedge CLK_I)
  begin
    if (MEM_REQ_O && MEM_ACK_I)
      lq.push_back({MEM_WE_O, MEM_AM_O, MEM_SIZE_O, MEM_ADDR_O});
    if (DOUT_VALID_O && DOUT_READY_I)
      dq.push_back({DOUT_SIZE_O, DOUT_DATA_O});
    if (DIN_VALID_I && DIN_READY_O)
      DIN_DATA_I <= DIN_DATA_I + 32'h0000_0001;
  end
  task automatic chk(input string n, input logic [63:0] s, e);
    checks_done++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    @(posedge CLK_I);
    S_AXI_AWADDR_I <= a;
    S_AXI_WDATA_I <= d;
    S_AXI_AWVALID_I <= 1'b1;
    S_AXI_WVALID_I <= 1'b1;
    S_AXI_BREADY_I <= 1'b1;
    do
    begin
      @(posedge CLK_I);
      if (S_AXI_AWREADY_O)
        S_AXI_AWVALID_I <= 1'b0;
      if (S_AXI_WREADY_O)
        S_AXI_WVALID_I <= 1'b0;
    end
    while (S_AXI_BVALID_O !== 1'b1);
    r = S_AXI_BRESP_O;
    S_AXI_BREADY_I <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge CLK_I);
    S_AXI_ARADDR_I <= a;
    S_AXI_ARVALID_I <= 1'b1;
    S_AXI_RREADY_I <= 1'b1;
    do
    begin
      @(posedge CLK_I);
      if (S_AXI_ARREADY_O)
        S_AXI_ARVALID_I <= 1'b0;
    end
    while (S_AXI_RVALID_O !== 1'b1);
    d = S_AXI_RDATA_O;
    r = S_AXI_RRESP_O;
    S_AXI_RREADY_I <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input int e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(n, d, e);
  endtask
  task automatic wait_done(output logic [31:0] s);
    logic [1:0] r;
    do
      axi_rd(SGD_STAT_OFS, s, r);
    while (s[SGD_DONE_BIT] !== 1'b1);
    wr(SGD_STAT_OFS, 32'h0000_0002);
    rd_chk("done clear", SGD_STAT_OFS, s & ~32'h0000_0002);
  endtask
  task automatic wm(input int a, input logic [31:0] d);
    sgd_mem_model_i.mem[a / 4] = d;
  endtask
  task automatic ex(input logic w, input logic [7:0] m, input logic [1:0] z,
    input int a);
    eq.push_back({w, m, z, 32'(a)});
  endtask
  task automatic exf(input int b);
    for (int i = 0; i < 17; i++)
      ex(1'b0, 8'h09, SGD_SZ32, b + 4 * i);
  endtask
  task automatic cmp_log(input string n);
    chk({n, " count"}, lq.size(), eq.size());
    foreach (eq[i])
      chk(n, lq[i], eq[i]);
    lq.delete();
    eq.delete();
    dq.delete();
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 6; i++)
    begin
      axi_rd(8'(4 * i), d, r);
      chk("reset value", d, i == 0 ? SGD_CTRL_RST : SGD_WORD_RST);
      chk("read resp", r, i == 5 ? SGD_SLVERR : SGD_OKAY);
    end
    axi_wr(8'h14, 32'h0000_0001, r);
    chk("unmapped write", r, SGD_SLVERR);
    $display("end of t_regs");
  endtask
  task automatic t_contig();
    logic [31:0] s;
    wm(32'h0000_0180, 32'h1111_2222);
    wm(32'h0000_0184, 32'h3333_4444);
    wr(SGD_ADDR_OFS, 32'h0000_0180);
    wr(SGD_COUNT_OFS, 32'h0000_0008);
    wr(SGD_CTRL_OFS, 32'h0000_0911);
    wait_done(s);
    chk("contig data", dq[1], {SGD_SZ32, 32'h3333_4444});
    ex(1'b0, 8'h09, SGD_SZ32, 32'h0000_0180);
    ex(1'b0, 8'h09, SGD_SZ32, 32'h0000_0184);
    cmp_log("contig beat");
    $display("end of t_contig");
  endtask
  task automatic t_sg();
    logic [31:0] s;
    // Three blocks: zero length stop, eight full segments, empty end
    wm(32'h0000_0000, 32'h0000_0080);
    wm(32'h0000_0004, 32'h3D00_0004);
    wm(32'h0000_0008, 32'h0000_0200);
    wm(32'h0000_000C, 32'h3E00_0006);
    wm(32'h0000_0010, 32'h0000_0302);
    wm(32'h0000_001C, 32'h3F00_0008);
    wm(32'h0000_0020, 32'h0000_0210);
    wm(32'h0000_0080, 32'h0000_0100);
    for (int n = 1; n <= 8; n++)
    begin
      wm(32'h7C + 8 * n, {8'(8'h10 + n), 24'h00_0001});
      wm(32'h80 + 8 * n, 32'h37F + n);
    end
    wm(32'h0000_0100, SGD_END_MARK);
    wm(32'h0000_0200, 32'hA5A5_0001);
    @(posedge CLK_I);
    DOUT_READY_I <= 1'b0;
    slow <= 1'b1;
    wr(SGD_ADDR_OFS, 32'h0000_0000);
    wr(SGD_COUNT_OFS, 32'h0000_0012);
    wr(SGD_CTRL_OFS, 32'h0000_0913);
    wr(SGD_ADDR_OFS, 32'h0000_0055);
    rd_chk("busy write", SGD_ADDR_OFS, 0);
    repeat (300) @(posedge CLK_I);
    chk("stall valid", DOUT_VALID_O, 1'b1);
    chk("stall count", dq.size(), 0);
    DOUT_READY_I <= 1'b1;
    wait_done(s);
    chk("end marker", s & 32'h0000_0023, 32'h0000_0022);
    chk("words out", dq.size(), 12);
    chk("seg1 word", dq[0], {SGD_SZ32, 32'hA5A5_0001});
    chk("seg2 size", dq[1][33:32], SGD_SZ16);
    chk("seg8 size", dq[11][33:32], SGD_SZ8);
    exf(0);
    ex(1'b0, 8'h3D, SGD_SZ32, 32'h0000_0200);
    for (int b = 2; b < 8; b += 2)
      ex(1'b0, 8'h3E, SGD_SZ16, 32'h300 + b);
    exf(32'h0000_0080);
    for (int n = 1; n <= 8; n++)
      ex(1'b0, 8'(8'h10 + n), SGD_SZ8, 32'h37F + n);
    exf(32'h0000_0100);
    cmp_log("sg beat");
    rd_chk("bytes moved", SGD_MOVED_OFS, 18);
    slow <= 1'b0;
    $display("end of t_sg");
  endtask
  task automatic t_write();
    logic [31:0] s;
    // Pass 2 runs odd-byte on a 16-bit bus
    for (int k = 0; k < 3; k++)
    begin
      wr(SGD_ADDR_OFS, 32'h0000_0201);
      wr(SGD_COUNT_OFS, 32'h0000_0008);
      DIN_VALID_I <= 1'b1;
      wr(SGD_CTRL_OFS, k == 2 ? 32'h0000_090D :
        k ? 32'h0000_091D : 32'h0000_0915);
      wait_done(s);
      DIN_VALID_I <= 1'b0;
      if (k == 0)
        for (int b = 0; b < 8; b++)
          ex(1'b1, 8'h09, SGD_SZ8, 32'h201 + b);
      else
      begin
        ex(1'b1, 8'h09, SGD_SZ8, 32'h0000_0201);
        if (k == 1)
        begin
          ex(1'b1, 8'h09, SGD_SZ16, 32'h0000_0202);
          ex(1'b1, 8'h09, SGD_SZ32, 32'h0000_0204);
        end
        else
          for (int b = 2; b < 8; b += 2)
            ex(1'b1, 8'h09, SGD_SZ16, 32'h200 + b);
        ex(1'b1, 8'h09, SGD_SZ8, 32'h0000_0208);
      end
      cmp_log("write beat");
      // Two words stay buffered between passes
      chk("last wdata", sgd_mem_model_i.mem[8'h82],
        k == 2 ? 16 : k ? 11 : 7);
    end
    $display("end of t_write");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge CLK_I);
    RST_I <= 1'b0;
    t_regs();
    t_contig();
    t_sg();
    t_write();
    test_done();
  end
  // Whole run needs well under a third of this
  initial
  begin
    #300000;
    error_cnt++;
    test_done();
  end
endmodule // test_sgd_dma
